// file: logic/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int LINE_COUNT = 496;
  localparam int WORD_COUNT = 16;
  localparam int PRIO_WORDS = 124;
  localparam int PRIO_WIDTH = 8;
  localparam int IRQ_NUM_W  = 9;

  typedef logic [LINE_COUNT-1:0] line_vec_t;

  // Exception number of a line is its line number plus this offset.
  localparam logic [IRQ_NUM_W-1:0] EXC_NUM_OFFSET = 9'h010;

  // ---------------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------------
  localparam logic [31:0] TYPE_INFO_ADDR  = 32'hE000_E004;
  localparam logic [31:0] CTRL_ADDR       = 32'hE000_E008;
  localparam logic [31:0] SET_EN_BASE     = 32'hE000_E100;
  localparam logic [31:0] CLR_EN_BASE     = 32'hE000_E180;
  localparam logic [31:0] SET_PEND_BASE   = 32'hE000_E200;
  localparam logic [31:0] CLR_PEND_BASE   = 32'hE000_E280;
  localparam logic [31:0] ACTIVE_BASE     = 32'hE000_E300;
  localparam logic [31:0] PRIO_BASE       = 32'hE000_E400;
  localparam logic [31:0] PRIO_LAST       = 32'hE000_E5EC;
  localparam logic [31:0] SOFT_TRIG_ADDR  = 32'hE000_EF00;
  localparam logic [31:0] BIT_WORD_SPAN   = 32'h0000_003C;

  // ---------------------------------------------------------------------------
  // Fields and fixed values
  // ---------------------------------------------------------------------------
  localparam int          CLEAR_ALL_BIT   = 1;
  localparam logic [31:0] TYPE_INFO_VALUE = 32'h0000_000F;

  // Per-line options: software pending control, tied enables, implemented lines.
  localparam line_vec_t SW_SET_MASK     = '1;
  localparam line_vec_t SW_CLR_MASK     = '1;
  localparam line_vec_t ENABLE_TIED_ONE = '0;
  localparam line_vec_t IMPL_MASK       = '1;

  // ---------------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------------
  localparam line_vec_t         ENABLE_RESET  = '0;
  localparam line_vec_t         PENDING_RESET = '0;
  localparam line_vec_t         ACTIVE_RESET  = '0;
  localparam logic [PRIO_WIDTH-1:0] PRIO_RESET = 8'h00;
  localparam logic [31:0]       RDATA_RESET   = 32'h0000_0000;

endpackage : irq_ctrl_pkg

// file: logic/irq_sample_if.sv
`timescale 1ns/100ps
interface irq_sample_if
  import irq_ctrl_pkg::*;
();
  line_vec_t level;
  line_vec_t rise;

  modport source (output level, output rise);
  modport sink   (input level, input rise);
endinterface : irq_sample_if

// file: logic/irq_input_sampler.sv
`timescale 1ns/100ps
module irq_input_sampler
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic    ref_clk,
  input  wire logic    rst_n,
  // Raw interrupt requests
  input  wire line_vec_t irqIn,
  // Sampled levels and rising edges
  irq_sample_if.source smp
);

  typedef struct packed {
    line_vec_t sync1;
    line_vec_t sync2;
    line_vec_t prev;
  } sampler_state_t;

  sampler_state_t cur;
  sampler_state_t next_state;

  // ---------------------------------------------------------------------------
  // Synchroniser and edge detector
  // ---------------------------------------------------------------------------
  // two-stage input synchroniser
  always_comb begin
    next_state       = cur;
    next_state.sync1 = irqIn;
    next_state.sync2 = cur.sync1;
    next_state.prev  = cur.sync2;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_state;
    end
  end

  assign smp.level = cur.sync2;
  assign smp.rise  = cur.sync2 & ~cur.prev;

endmodule : irq_input_sampler

// file: logic/nested_irq_controller.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module nested_irq_controller
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire logic [31:0]           addr,
  input  wire logic [31:0]           wrData,
  input  wire logic                  wrEn,
  input  wire logic                  rdEn,
  output      logic [31:0]           rdData,
  // Interrupt request inputs
  input  wire line_vec_t             irqIn,
  // Core exception logic
  input  wire logic                  excEntry,
  input  wire logic [IRQ_NUM_W-1:0]  excEntryIrq,
  input  wire logic                  excReturn,
  input  wire logic [IRQ_NUM_W-1:0]  excReturnIrq,
  input  wire logic [IRQ_NUM_W-1:0]  prioQueryIrq,
  output      logic [PRIO_WIDTH-1:0] prioQuery,
  output      logic [IRQ_NUM_W-1:0]  queryExcNum,
  output      line_vec_t             lineEnabled,
  output      line_vec_t             linePending,
  output      line_vec_t             lineActive
);

  typedef struct packed {
    line_vec_t                             enable;
    line_vec_t                             pending;
    line_vec_t                             active;
    logic [LINE_COUNT-1:0][PRIO_WIDTH-1:0] prio;
    logic [31:0]                           rdata;
    logic [PRIO_WIDTH-1:0]                 prioOut;
    logic [IRQ_NUM_W-1:0]                  excNumOut;
  } ctrl_state_t;

  ctrl_state_t cur;
  ctrl_state_t next_state;

  irq_sample_if smp ();

  // ---------------------------------------------------------------------------
  // Input sampling
  // ---------------------------------------------------------------------------
  irq_input_sampler u_sampler (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .irqIn   (irqIn),
    .smp     (smp)
  );

  // ---------------------------------------------------------------------------
  // Word helpers
  // ---------------------------------------------------------------------------
  // Spreads a 32-bit word over the line vector at the given word index.
  function automatic line_vec_t placeWord(input logic [31:0] d, input logic [3:0] idx);
    logic [WORD_COUNT*32-1:0] w;
    w                  = '0;
    w[{idx, 5'b0} +: 32] = d;
    return w[LINE_COUNT-1:0];
  endfunction : placeWord

  // Picks one 32-bit word out of a line vector; missing lines read zero.
  function automatic logic [31:0] getWord(input line_vec_t v, input logic [3:0] idx);
    logic [WORD_COUNT*32-1:0] w;
    w = {{(WORD_COUNT*32-LINE_COUNT){1'b0}}, v & IMPL_MASK};
    return w[{idx, 5'b0} +: 32];
  endfunction : getWord

  // Tells whether an address falls in a 16-word bit-array block.
  function automatic logic inBlock(input logic [31:0] a, input logic [31:0] base);
    return (a >= base) && (a <= base + BIT_WORD_SPAN);
  endfunction : inBlock

  // ---------------------------------------------------------------------------
  // Decoded software events
  // ---------------------------------------------------------------------------
  line_vec_t                swSetEn;
  line_vec_t                swClrEn;
  line_vec_t                swSetPend;
  line_vec_t                swClrPend;
  logic                     clrAll;
  logic [31:0]              readWord;
  logic [6:0]               prioIdx;
  logic [3:0]               wrIdx;
  logic [3:0]               rdIdx;
  logic [31:0]              prioOff;
  // Per-line pending set and clear terms, merged below with set taking priority.
  line_vec_t                pendSet;
  line_vec_t                pendClr;

  assign wrIdx   = addr[5:2];
  assign rdIdx   = addr[5:2];
  assign prioOff = addr - PRIO_BASE;
  assign prioIdx = prioOff[8:2];

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // One select value per register block.
  typedef enum {
    SEL_NONE,
    SEL_TYPE,
    SEL_CTRL,
    SEL_SET_EN,
    SEL_CLR_EN,
    SEL_SET_PEND,
    SEL_CLR_PEND,
    SEL_ACTIVE,
    SEL_PRIO,
    SEL_SOFT
  } reg_sel_t;

  reg_sel_t regSel;

  // Reserved holes between the blocks select nothing, so they read zero.
  always_comb begin
    if (addr == TYPE_INFO_ADDR) begin
      regSel = SEL_TYPE;
    end else if (addr == CTRL_ADDR) begin
      regSel = SEL_CTRL;
    end else if (inBlock(addr, SET_EN_BASE)) begin
      regSel = SEL_SET_EN;
    end else if (inBlock(addr, CLR_EN_BASE)) begin
      regSel = SEL_CLR_EN;
    end else if (inBlock(addr, SET_PEND_BASE)) begin
      regSel = SEL_SET_PEND;
    end else if (inBlock(addr, CLR_PEND_BASE)) begin
      regSel = SEL_CLR_PEND;
    end else if (inBlock(addr, ACTIVE_BASE)) begin
      regSel = SEL_ACTIVE;
    end else if ((addr >= PRIO_BASE) && (addr <= PRIO_LAST)) begin
      regSel = SEL_PRIO;
    end else if (addr == SOFT_TRIG_ADDR) begin
      regSel = SEL_SOFT;
    end else begin
      regSel = SEL_NONE;
    end
  end

  // ---------------------------------------------------------------------------
  // Core exception events
  // ---------------------------------------------------------------------------
  // One-hot vectors of the line that the core enters or leaves this cycle.
  line_vec_t entryHit;
  line_vec_t retHit;

  // Line numbers past the last line match nothing.
  always_comb begin
    entryHit = '0;
    retHit   = '0;
    if (excEntry && (excEntryIrq < IRQ_NUM_W'(LINE_COUNT))) begin
      entryHit[excEntryIrq] = 1'b1;
    end
    if (excReturn && (excReturnIrq < IRQ_NUM_W'(LINE_COUNT))) begin
      retHit[excReturnIrq] = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = cur;
    swSetEn    = '0;
    swClrEn    = '0;
    swSetPend  = '0;
    swClrPend  = '0;
    clrAll     = 1'b0;
    readWord   = 32'h0000_0000;
    pendSet    = '0;
    pendClr    = '0;

    // -------------------------------------------------------------------------
    // Register writes; unmapped and read-only addresses are ignored.
    // -------------------------------------------------------------------------
    if (wrEn) begin
      case (regSel)
        SEL_SET_EN: begin
          swSetEn = placeWord(wrData, wrIdx);
        end
        SEL_CLR_EN: begin
          swClrEn = placeWord(wrData, wrIdx);
        end
        SEL_SET_PEND: begin
          swSetPend = placeWord(wrData, wrIdx) & SW_SET_MASK;
        end
        SEL_CLR_PEND: begin
          swClrPend = placeWord(wrData, wrIdx) & SW_CLR_MASK;
        end
        SEL_SOFT: begin
          if (wrData[IRQ_NUM_W-1:0] < IRQ_NUM_W'(LINE_COUNT)) begin
            swSetPend[wrData[IRQ_NUM_W-1:0]] = 1'b1;
          end
        end
        SEL_CTRL: begin
          // Clearing all active lines also re-pends those still held high.
          clrAll = wrData[CLEAR_ALL_BIT];
        end
        SEL_PRIO: begin
          for (int k = 0; k < 4; k++) begin
            if (IMPL_MASK[{prioIdx, 2'(k)}]) begin
              next_state.prio[{prioIdx, 2'(k)}] = wrData[k*8 +: 8];
            end
          end
        end
        default: begin
          clrAll = 1'b0;
        end
      endcase
    end

    // -------------------------------------------------------------------------
    // Per-line enable, pending and active state.
    // -------------------------------------------------------------------------
    // state kept per line
    for (int i = 0; i < LINE_COUNT; i++) begin
      next_state.enable[i] = IMPL_MASK[i]
                           & (ENABLE_TIED_ONE[i] | swSetEn[i] | (cur.enable[i] & ~swClrEn[i]));
      pendSet[i] = smp.rise[i] | (smp.level[i] & (clrAll | retHit[i])) | swSetPend[i];
      pendClr[i] = (entryHit[i] & cur.enable[i]) | (~smp.level[i] & swClrPend[i]);
      next_state.pending[i] = IMPL_MASK[i] & (pendSet[i] | (cur.pending[i] & ~pendClr[i]));
      next_state.active[i] = IMPL_MASK[i]
                           & ((cur.active[i] & ~(clrAll | retHit[i]))
                           |  (entryHit[i] & cur.enable[i]));
    end

    // -------------------------------------------------------------------------
    // Register reads; data stands only in the following cycle.
    // -------------------------------------------------------------------------
    if (rdEn) begin
      case (regSel)
        SEL_TYPE: begin
          readWord = TYPE_INFO_VALUE;
        end
        SEL_SET_EN, SEL_CLR_EN: begin
          readWord = getWord(cur.enable, rdIdx);
        end
        SEL_SET_PEND, SEL_CLR_PEND: begin
          readWord = getWord(cur.pending, rdIdx);
        end
        SEL_ACTIVE: begin
          readWord = getWord(cur.active, rdIdx);
        end
        SEL_PRIO: begin
          for (int k = 0; k < 4; k++) begin
            if (IMPL_MASK[{prioIdx, 2'(k)}]) begin
              readWord[k*8 +: 8] = cur.prio[{prioIdx, 2'(k)}];
            end
          end
        end
        default: begin
          readWord = 32'h0000_0000;
        end
      endcase
    end
    next_state.rdata = readWord;

    // -------------------------------------------------------------------------
    // Answers to the core's priority query.
    // -------------------------------------------------------------------------
    // priority and exception number
    if (prioQueryIrq < IRQ_NUM_W'(LINE_COUNT)) begin
      next_state.prioOut = cur.prio[prioQueryIrq];
    end else begin
      next_state.prioOut = PRIO_RESET;
    end
    // exception number is line plus 16
    // The sum wraps in nine bits; the core only asks for existing lines.
    next_state.excNumOut = IRQ_NUM_W'(prioQueryIrq + EXC_NUM_OFFSET);
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // all updates on ref_clk
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur.enable    <= ENABLE_RESET;
      cur.pending   <= PENDING_RESET;
      cur.active    <= ACTIVE_RESET;
      cur.prio      <= {LINE_COUNT{PRIO_RESET}};
      cur.rdata     <= RDATA_RESET;
      cur.prioOut   <= PRIO_RESET;
      cur.excNumOut <= EXC_NUM_OFFSET;
    end else begin
      cur <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign rdData      = cur.rdata;
  assign prioQuery   = cur.prioOut;
  assign queryExcNum = cur.excNumOut;
  assign lineEnabled = cur.enable;
  assign linePending = cur.pending;
  assign lineActive  = cur.active;

endmodule : nested_irq_controller

// file: verif/irq_source_model.sv
`timescale 1ns/100ps
module irq_source_model
  import irq_ctrl_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // Requests towards the controller
  output line_vec_t irqIn
);
  initial irqIn = '0;

  task pulse(input int n);
    @(posedge ref_clk);
    irqIn[n] <= 1'b1;
    @(posedge ref_clk);
    irqIn[n] <= 1'b0;
  endtask : pulse

  task level(input int n, input logic v);
    @(posedge ref_clk);
    irqIn[n] <= v;
  endtask : level
endmodule : irq_source_model

// file: verif/nested_irq_controller_assertions.sv
`timescale 1ns/100ps
module nested_irq_controller_assertions
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  // Register port
  input wire logic [31:0]          addr,
  input wire logic [31:0]          wrData,
  input wire logic                 wrEn,
  input wire logic                 rdEn,
  input wire logic [31:0]          rdData,
  // Lines and core
  input wire line_vec_t            irqIn,
  input wire logic                 excEntry,
  input wire logic [IRQ_NUM_W-1:0] excEntryIrq,
  input wire logic                 excReturn,
  input wire logic [IRQ_NUM_W-1:0] excReturnIrq,
  input wire logic [IRQ_NUM_W-1:0] prioQueryIrq,
  input wire logic [IRQ_NUM_W-1:0] queryExcNum,
  input wire line_vec_t            lineEnabled,
  input wire line_vec_t            linePending,
  input wire line_vec_t            lineActive
);
  line_vec_t hi1;
  line_vec_t hi2;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // A line counts as steady high only after three samples, past the synchroniser.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi1 <= '0;
      hi2 <= '0;
    end else begin
      hi1 <= irqIn;
      hi2 <= hi1;
    end
  end
  wire logic clrAll = wrEn && addr == CTRL_ADDR && wrData[CLEAR_ALL_BIT];
  wire line_vec_t steady = irqIn & hi1 & hi2;
  wire logic clrPend = wrEn && addr >= CLR_PEND_BASE && addr <= CLR_PEND_BASE + BIT_WORD_SPAN;

  sequence s_rise;
    $rose(irqIn[5]);
  endsequence
  sequence s_hot_return;
    excReturn && steady[excReturnIrq];
  endsequence

  a_rdata_idle: assert property (
    !$past(rdEn) |-> rdData == 32'h0000_0000) else $error("read data outside its cycle");
  a_type_read: assert property (
    rdEn && addr == TYPE_INFO_ADDR |=> rdData == 32'h0000_000F) else $error("type value wrong");
  a_exc_offset: assert property (
    queryExcNum == 9'($past(prioQueryIrq) + 9'h010)) else $error("exception number wrong");
  a_edge_pend: assert property (
    s_rise |-> ##3 linePending[5]) else $error("rise did not pend");
  a_disabled_noact: assert property (
    excEntry && !lineEnabled[excEntryIrq] && !lineActive[excEntryIrq]
    |=> !lineActive[$past(excEntryIrq)]) else $error("disabled line activated");
  a_entry_act: assert property (
    excEntry && lineEnabled[excEntryIrq] |=> lineActive[$past(excEntryIrq)]
    && !linePending[$past(excEntryIrq)]) else $error("entry not taken");
  a_clrpend_keeps: assert property (
    clrPend && !excEntry && !excReturn |=> lineActive == $past(lineActive))
    else $error("clear pending moved active");
  a_active_holds: assert property (
    !excReturn && !clrAll |=> (lineActive & $past(lineActive)) == $past(lineActive))
    else $error("active dropped");
  a_return_repend: assert property (
    s_hot_return |=> linePending[$past(excReturnIrq)]) else $error("level not pended again");
endmodule : nested_irq_controller_assertions

bind nested_irq_controller nested_irq_controller_assertions nested_irq_controller_assertions_i (
  .ref_clk, .rst_n, .addr, .wrData, .wrEn, .rdEn, .rdData, .irqIn, .excEntry,
  .excEntryIrq, .excReturn, .excReturnIrq, .prioQueryIrq, .queryExcNum,
  .lineEnabled, .linePending, .lineActive);

// file: verif/nested_irq_controller_tb_top.sv
`timescale 1ns/100ps
module nested_irq_controller_tb_top
  import irq_ctrl_pkg::*;
();
  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [31:0]           addr = 32'h0000_0000;
  logic [31:0]           wrData = 32'h0000_0000;
  logic                  wrEn = 1'b0;
  logic                  rdEn = 1'b0;
  logic                  excEntry = 1'b0;
  logic                  excReturn = 1'b0;
  logic [IRQ_NUM_W-1:0]  excEntryIrq = 9'h000;
  logic [IRQ_NUM_W-1:0]  excReturnIrq = 9'h000;
  logic [IRQ_NUM_W-1:0]  prioQueryIrq = 9'h000;
  logic [IRQ_NUM_W-1:0]  queryExcNum;
  logic [PRIO_WIDTH-1:0] prioQuery;
  logic [31:0]           rdData;
  line_vec_t             irqIn, lineEnabled, linePending, lineActive;
  int                    n_fail = 0;
  int                    compares = 0;

  always #2 ref_clk = ~ref_clk;

  nested_irq_controller nested_irq_controller_i (.ref_clk, .rst_n, .addr, .wrData,
    .wrEn, .rdEn, .rdData, .irqIn, .excEntry, .excEntryIrq, .excReturn,
    .excReturnIrq, .prioQueryIrq, .prioQuery, .queryExcNum, .lineEnabled,
    .linePending, .lineActive);
  irq_source_model irq_source_model_i (.ref_clk, .irqIn);

  task summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge ref_clk);
    wrEn <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    #1;
    chk(rdData, e);
  endtask : rd
  task exc(input logic back, input int n);
    @(posedge ref_clk);
    excEntryIrq <= 9'(n);
    excReturnIrq <= 9'(n);
    excEntry <= !back;
    excReturn <= back;
    @(posedge ref_clk);
    excEntry <= 1'b0;
    excReturn <= 1'b0;
    wt(1);
  endtask : exc

  task t_regs;
    rd(TYPE_INFO_ADDR, 32'h0000_000F);
    rd(SET_EN_BASE, 32'h0000_0000);
    rd(32'hE000_E340, 32'h0000_0000);
    wr(SET_EN_BASE + 32'h0000_003C, 32'hFFFF_FFFF);
    rd(CLR_EN_BASE + 32'h0000_003C, 32'h0000_FFFF);
    wr(CLR_EN_BASE + 32'h0000_003C, 32'hFFFF_FFFF);
    wr(SET_EN_BASE, 32'h0000_00A0);
    wr(SET_EN_BASE, 32'h0000_0000);
    wr(CLR_EN_BASE, 32'h0000_0080);
    rd(CLR_EN_BASE, 32'h0000_0020);
    wr(PRIO_BASE + 32'h0000_0004, 32'hA1B2_C3D4);
    rd(PRIO_BASE + 32'h0000_0004, 32'hA1B2_C3D4);
    @(posedge ref_clk);
    prioQueryIrq <= 9'h006;
    wt(1);
    chk(32'(prioQuery), 32'h0000_00B2);
    chk(32'(queryExcNum), 32'h0000_0016);
  endtask : t_regs
  task t_soft;
    wr(SET_PEND_BASE, 32'h0000_0008);
    rd(CLR_PEND_BASE, 32'h0000_0008);
    wr(SOFT_TRIG_ADDR, 32'h0000_0028);
    wr(SOFT_TRIG_ADDR, 32'h0000_01F0);
    rd(SET_PEND_BASE + 32'h0000_0004, 32'h0000_0100);
    rd(SET_PEND_BASE + 32'h0000_003C, 32'h0000_0000);
    wr(CLR_PEND_BASE, 32'h0000_0008);
    rd(SET_PEND_BASE, 32'h0000_0000);
  endtask : t_soft
  task t_pulse;
    wr(CLR_EN_BASE, 32'h0000_0020);
    irq_source_model_i.pulse(5);
    wt(3);
    exc(1'b0, 5);
    chk(32'(lineActive[5]), 32'h0000_0000);
    chk(32'(linePending[5]), 32'h0000_0001);
    wr(SET_EN_BASE, 32'h0000_0020);
    exc(1'b0, 5);
    chk(32'(linePending[5]), 32'h0000_0000);
    chk(32'(lineEnabled[5]), 32'h0000_0001);
    irq_source_model_i.pulse(5);
    irq_source_model_i.pulse(5);
    wt(3);
    rd(ACTIVE_BASE, 32'h0000_0020);
    rd(SET_PEND_BASE, 32'h0000_0020);
    wr(CLR_PEND_BASE, 32'h0000_0020);
    rd(ACTIVE_BASE, 32'h0000_0020);
    wr(CLR_EN_BASE, 32'h0000_0020);
    rd(ACTIVE_BASE, 32'h0000_0020);
    chk(32'(lineEnabled[5]), 32'h0000_0000);
    exc(1'b1, 5);
    rd(ACTIVE_BASE, 32'h0000_0000);
    rd(SET_PEND_BASE, 32'h0000_0000);
  endtask : t_pulse
  task t_level;
    wr(SET_EN_BASE, 32'h0000_0200);
    irq_source_model_i.level(9, 1'b1);
    wt(4);
    wr(CLR_PEND_BASE, 32'h0000_0200);
    rd(SET_PEND_BASE, 32'h0000_0200);
    exc(1'b0, 9);
    exc(1'b1, 9);
    chk(32'(linePending[9]), 32'h0000_0001);
    exc(1'b0, 9);
    wr(CTRL_ADDR, 32'h0000_0002);
    rd(ACTIVE_BASE, 32'h0000_0000);
    rd(SET_PEND_BASE, 32'h0000_0200);
    irq_source_model_i.level(9, 1'b0);
    wt(3);
    wr(CLR_PEND_BASE, 32'h0000_0200);
    rd(SET_PEND_BASE, 32'h0000_0000);
  endtask : t_level

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_soft();
    t_pulse();
    t_level();
    summarize();
  end
  // The tests need well under a thousand cycles, so 20000 means a hang.
  initial begin
    #80000;
    n_fail++;
    summarize();
  end
endmodule : nested_irq_controller_tb_top
